/* File: hw/aqe_pkg.sv */
package aqe_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ        = 250_000_000;
	localparam int unsigned SAMPLE_HZ     = 10_000;
	localparam int unsigned SAMPLE_MIN_HZ = 9_500;
	localparam int unsigned SAMPLE_MAX_HZ = 10_500;
	localparam int unsigned SAMPLE_CYC    = CLK_HZ / SAMPLE_HZ;
	localparam int unsigned POWER_UP_INTERVAL_MS      = 50;
	localparam int unsigned POWER_UP_INTERVAL_CYC     = (CLK_HZ / 1000) * POWER_UP_INTERVAL_MS;
	localparam int unsigned RELEASE_NS    = 500;
	localparam int unsigned RELEASE_CYC   = (RELEASE_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int unsigned PROP_US       = 192;
	localparam int unsigned PROP_CYC      = PROP_US * (CLK_HZ / 1_000_000);
	localparam int unsigned MAX_REV_HZ    = 500;

	// ==========================================================
	// angle format
	localparam int unsigned POS_W      = 8;
	localparam int unsigned HALF_W     = POS_W + 1;
	localparam int unsigned STEP_GAP   = 4;
	localparam int unsigned PWR_CNT_W  = 24;
	localparam int unsigned SMP_CNT_W  = 16;

	// ==========================================================
	// hysteresis thresholds, in half steps from twice the position
	localparam logic signed [HALF_W-1:0] UP_FWD  = 9'sh002;
	localparam logic signed [HALF_W-1:0] DN_FWD  = -9'sh002;
	localparam logic signed [HALF_W-1:0] UP_REV  = 9'sh002;
	localparam logic signed [HALF_W-1:0] DN_REV  = -9'sh002;

	// ==========================================================
	// reset values
	localparam logic [1:0] SYNC_RST = 2'h0;
	localparam logic       OUT_RST  = 1'h1;

	typedef enum logic [1:0] {
		AQE_POWER_UP_INTERVAL = 2'h0,
		AQE_DIAG  = 2'h1,
		AQE_RUN   = 2'h2
	} aqe_phase_t;

endpackage : aqe_pkg

/* File: hw/aqe_encoder.sv */
`timescale 1ns/100ps
module aqe_encoder #(
	parameter int unsigned POWER_UP_INTERVAL_CYC  = aqe_pkg::POWER_UP_INTERVAL_CYC,
	parameter int unsigned SAMPLE_CYC = aqe_pkg::SAMPLE_CYC,
	parameter int unsigned STEP_GAP   = aqe_pkg::STEP_GAP
) (
	input  wire logic                        ref_clk_in,
	input  wire logic                        rst_in,
	input  wire logic [aqe_pkg::HALF_W-1:0]  angle_in,
	input  wire logic                        output_release_n_in,
	output logic                             phase_a_out,
	output logic                             phase_b_out,
	output logic                             index_out,
	output logic                             outputs_valid_out
);

	// ==========================================================
	// elaboration checks
	if (POWER_UP_INTERVAL_CYC < 4) begin : g_power_up_interval_short
		$error("power-up count too small");
	end
	if (POWER_UP_INTERVAL_CYC >= (1 << aqe_pkg::PWR_CNT_W)) begin : g_power_up_interval_long
		$error("power-up count too large for its counter");
	end
	if (SAMPLE_CYC < 4) begin : g_sample_short
		$error("sample count too small");
	end
	if (SAMPLE_CYC >= (1 << aqe_pkg::SMP_CNT_W)) begin : g_sample_long
		$error("sample count too large for its counter");
	end
	if (STEP_GAP < 1) begin : g_gap_short
		$error("step gap must be at least one cycle");
	end
	if (STEP_GAP > 255) begin : g_gap_long
		$error("step gap too large for its counter");
	end
	// a full turn of steps must fit in one sample period
	if (STEP_GAP * (1 << aqe_pkg::POS_W) >= SAMPLE_CYC) begin : g_gap_vs_sample
		$error("step gap too long for sample period");
	end
	// release path is the sync plus one register, far inside the limit
	if (aqe_pkg::RELEASE_CYC < 4) begin : g_release_budget
		$error("release latency budget too small");
	end
	// the input grid carries exactly one half-step bit below the code
	if (aqe_pkg::HALF_W != aqe_pkg::POS_W + 1) begin : g_grid_width
		$error("angle input width must be code width plus one");
	end
	if (aqe_pkg::UP_FWD <= 0 || aqe_pkg::DN_FWD >= 0) begin : g_band_sign
		$error("step thresholds must straddle zero");
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic [1:0]                        sync;
		logic                              saw_high;
		aqe_pkg::aqe_phase_t               phase;
		logic [aqe_pkg::PWR_CNT_W-1:0]     pwr_cnt;
		logic [aqe_pkg::SMP_CNT_W-1:0]     smp_cnt;
		logic [aqe_pkg::HALF_W-1:0]        prev;
		logic [aqe_pkg::HALF_W-1:0]        cur;
		logic [aqe_pkg::POS_W-1:0]         pos;
		logic                              dir_up;
		logic [7:0]                        gap_cnt;
		logic                              a;
		logic                              b;
		logic                              idx;
	} aqe_state_t;

	aqe_state_t state_ff;
	aqe_state_t nxt_state;

	// gray phase pair for a position; zero code lines up with index
	function automatic logic [1:0] aqe_gray(input logic [1:0] p);
		case (p)
			2'h0:    aqe_gray = 2'h0;
			2'h1:    aqe_gray = 2'h2;
			2'h2:    aqe_gray = 2'h3;
			2'h3:    aqe_gray = 2'h1;
			default: aqe_gray = 2'h0;
		endcase
	endfunction : aqe_gray

	// the band spans three half steps, so a turn-back waits a full step
	function automatic logic [1:0] aqe_step(
		input logic signed [aqe_pkg::HALF_W-1:0] e,
		input logic                              up
	);
		logic signed [aqe_pkg::HALF_W-1:0] hi;
		logic signed [aqe_pkg::HALF_W-1:0] lo;
		hi       = up ? aqe_pkg::UP_FWD : aqe_pkg::UP_REV;
		lo       = up ? aqe_pkg::DN_FWD : aqe_pkg::DN_REV;
		aqe_step = {(e >= hi), (e <= lo)};
	endfunction : aqe_step

	// ==========================================================
	// next state
	logic [aqe_pkg::HALF_W-1:0]        diff_smp;
	logic [aqe_pkg::HALF_W-1:0]        target;
	logic signed [aqe_pkg::HALF_W-1:0] err;
	logic                              step_up;
	logic                              step_dn;
	logic [1:0]                        ab;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.sync = {state_ff.sync[0], output_release_n_in};

		// aim at the midpoint of the last two samples, half a sample period behind cur
		diff_smp = state_ff.cur - state_ff.prev;
		target   = state_ff.prev + {diff_smp[aqe_pkg::HALF_W-1],
			diff_smp[aqe_pkg::HALF_W-1:1]};
		err      = $signed(target - {state_ff.pos, 1'h0});

		// a wider band would shift the pulses by more than half a step
		{step_up, step_dn} = aqe_step(err, state_ff.dir_up);

		// sample clock
		if (state_ff.smp_cnt == aqe_pkg::SMP_CNT_W'(SAMPLE_CYC - 1)) begin
			nxt_state.smp_cnt = '0;
			nxt_state.prev    = state_ff.cur;
			nxt_state.cur     = angle_in;
		end else begin
			nxt_state.smp_cnt = state_ff.smp_cnt + 1'b1;
		end

		if (state_ff.gap_cnt != 8'h00)
			nxt_state.gap_cnt = state_ff.gap_cnt - 1'b1;

		case (state_ff.phase)
			aqe_pkg::AQE_POWER_UP_INTERVAL: begin
				if (state_ff.sync[1])
					nxt_state.saw_high = 1'b1;
				// track the angle so the first run cycle does not burst
				nxt_state.pos = target[aqe_pkg::HALF_W-1:1];
				nxt_state.pwr_cnt = state_ff.pwr_cnt + 1'b1;
				if (state_ff.pwr_cnt == aqe_pkg::PWR_CNT_W'(POWER_UP_INTERVAL_CYC - 1)) begin
					if (state_ff.saw_high || state_ff.sync[1])
						nxt_state.phase = aqe_pkg::AQE_DIAG;
					else
						nxt_state.phase = aqe_pkg::AQE_RUN;
				end
			end
			aqe_pkg::AQE_DIAG: begin
				nxt_state.pos = target[aqe_pkg::HALF_W-1:1];
				// low level after the interval is the first falling edge seen
				if (!state_ff.sync[1])
					nxt_state.phase = aqe_pkg::AQE_RUN;
			end
			aqe_pkg::AQE_RUN: begin
				// release is ignored from here on
				if (state_ff.gap_cnt == 8'h00 && (step_up || step_dn)) begin
					nxt_state.gap_cnt = 8'(STEP_GAP - 1);
					nxt_state.dir_up  = step_up;
					if (step_up)
						nxt_state.pos = state_ff.pos + 1'b1;
					else
						nxt_state.pos = state_ff.pos - 1'b1;
				end
			end
			default: begin
				nxt_state.phase = aqe_pkg::AQE_POWER_UP_INTERVAL;
			end
		endcase

		// outputs
		ab = aqe_gray(nxt_state.pos[1:0]);
		case (nxt_state.phase)
			aqe_pkg::AQE_RUN: begin
				nxt_state.a   = ab[1];
				nxt_state.b   = ab[0];
				nxt_state.idx = (nxt_state.pos == '0);
			end
			aqe_pkg::AQE_DIAG: begin
				nxt_state.a   = 1'b1;
				nxt_state.b   = 1'b1;
				nxt_state.idx = 1'b1;
			end
			default: begin
				// power-up: high once the pin was seen high, low otherwise
				nxt_state.a   = nxt_state.saw_high;
				nxt_state.b   = nxt_state.saw_high;
				nxt_state.idx = nxt_state.saw_high;
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_ff          <= '0;
			state_ff.sync     <= aqe_pkg::SYNC_RST;
			state_ff.phase    <= aqe_pkg::AQE_POWER_UP_INTERVAL;
			state_ff.dir_up   <= 1'b1;
			state_ff.a        <= aqe_pkg::OUT_RST;
			state_ff.b        <= aqe_pkg::OUT_RST;
			state_ff.idx      <= aqe_pkg::OUT_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign phase_a_out       = state_ff.a;
	assign phase_b_out       = state_ff.b;
	assign index_out         = state_ff.idx;
	assign outputs_valid_out = (state_ff.phase == aqe_pkg::AQE_RUN);

endmodule : aqe_encoder

/* File: dv/aqe_props.sv */
`timescale 1ns/100ps
module aqe_props #(
	parameter int unsigned POWER_UP_INTERVAL_CYC = 200
) (
	input wire logic                       ref_clk_in,
	input wire logic                       rst_in,
	input wire logic [aqe_pkg::HALF_W-1:0] angle_in,
	input wire logic                       output_release_n_in,
	input wire logic                       phase_a_out,
	input wire logic                       phase_b_out,
	input wire logic                       index_out,
	input wire logic                       outputs_valid_out
);
	// ==========
	// power-up tracking
	int unsigned cnt_ff;
	logic        low_ff;
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cnt_ff <= '0;
			low_ff <= 1'h1;
		end else begin
			if (cnt_ff < POWER_UP_INTERVAL_CYC + 32'h8) cnt_ff <= cnt_ff + 32'h1;
			if (cnt_ff < POWER_UP_INTERVAL_CYC) low_ff <= low_ff & ~output_release_n_in;
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	AST_NO_EARLY: assert property (cnt_ff < POWER_UP_INTERVAL_CYC - 4 |-> !outputs_valid_out)
		else $error("valid before power-up end");
	AST_AUTO_RUN: assert property (cnt_ff == POWER_UP_INTERVAL_CYC && low_ff |-> ##[0:3] outputs_valid_out)
		else $error("no run after power-up");
	AST_DIAG: assert property (!low_ff && cnt_ff > POWER_UP_INTERVAL_CYC + 2 && !outputs_valid_out
		|-> phase_a_out && phase_b_out && index_out)
		else $error("diag outputs not all high");
	AST_RELEASE: assert property (cnt_ff > POWER_UP_INTERVAL_CYC + 2 && $fell(output_release_n_in)
		|-> ##[0:125] outputs_valid_out)
		else $error("release too slow");
	AST_STAY: assert property (outputs_valid_out |=> outputs_valid_out)
		else $error("valid dropped");
	AST_IDX_AB: assert property (outputs_valid_out && index_out |-> !phase_a_out && !phase_b_out)
		else $error("index with a or b high");
	AST_ONE_EDGE: assert property (outputs_valid_out && $past(outputs_valid_out)
		|-> !($changed(phase_a_out) && $changed(phase_b_out)))
		else $error("both phases toggled");
	AST_HOLD: assert property (outputs_valid_out && $past(outputs_valid_out) && $changed(phase_a_out)
		|=> $stable(phase_a_out) [*3])
		else $error("phase level too short");
endmodule : aqe_props

/* File: dv/aqe_counter.sv */
`timescale 1ns/100ps
module aqe_counter (
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic phase_a_in,
	input  wire logic phase_b_in,
	input  wire logic valid_in,
	output int        count_out
);
	// ==========
	// quadrature decode, only between valid cycles so the diag exit is not counted
	logic [1:0] prev_ff;
	logic       vprev_ff;
	always_ff @(posedge ref_clk_in) begin
		prev_ff <= {phase_a_in, phase_b_in};
		vprev_ff <= valid_in & ~rst_in;
		if (rst_in || !valid_in) count_out <= 0;
		else if (vprev_ff) case ({prev_ff, phase_a_in, phase_b_in})
			4'h2, 4'hB, 4'hD, 4'h4: count_out <= count_out + 1;
			4'h8, 4'hE, 4'h7, 4'h1: count_out <= count_out - 1;
			default: ;
		endcase
	end
endmodule : aqe_counter

/* File: dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
	localparam int unsigned PU = 200;
	localparam int unsigned SC = 1100;
	logic                       clk = 1'h0, rst = 1'h1, rel_n = 1'h0;
	logic                       a, b, idx, vld;
	logic [aqe_pkg::HALF_W-1:0] ang = 9'h000;
	int                         cnt, mismatches = 0, checked = 0;
	int unsigned                n;
	aqe_encoder #(.POWER_UP_INTERVAL_CYC(PU), .SAMPLE_CYC(SC), .STEP_GAP(4)) i_dut (.ref_clk_in(clk),
		.rst_in(rst), .angle_in(ang), .output_release_n_in(rel_n), .phase_a_out(a),
		.phase_b_out(b), .index_out(idx), .outputs_valid_out(vld));
	aqe_counter i_cnt (.ref_clk_in(clk), .rst_in(rst), .phase_a_in(a), .phase_b_in(b),
		.valid_in(vld), .count_out(cnt));
	initial forever #2 clk = ~clk;
	// ==========
	// helpers
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %0h got %0h", s, e, g);
		end
	endtask : chk
	task automatic summarize();
		if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task automatic do_reset(input logic r);
		@(posedge clk);
		rel_n <= r;
		rst <= 1'h1;
		repeat (10) @(posedge clk);
		rst <= 1'h0;
	endtask : do_reset
	task automatic wait_valid(input int unsigned lim);
		for (n = 0; n < lim && vld !== 1'h1; n++) @(negedge clk);
		if (vld !== 1'h1) begin
			$display("[FAIL] valid_wait exp 1 got %0h", vld);
			mismatches++;
			summarize();
		end
	endtask : wait_valid
	task automatic go(input logic [8:0] v, input int e);
		@(posedge clk);
		ang <= v;
		repeat (3 * SC) @(negedge clk);
		chk("count", e, cnt);
	endtask : go
	// ==========
	// scenarios
	task automatic t_auto();
		do_reset(1'h0);
		wait_valid(PU + 20);
		chk("late_run", 1, n >= PU - 4);
		chk("zero_abi", 3'h1, {a, b, idx});
	endtask : t_auto
	task automatic t_move();
		go(9'h014, 10);
		go(9'h013, 10);
		go(9'h012, 9);
		go(9'h000, 0);
		go(9'h080, 64);
		go(9'h100, 128);
		go(9'h180, 192);
		go(9'h000, 256);
		chk("turn_abi", 3'h1, {a, b, idx});
	endtask : t_move
	task automatic t_diag();
		do_reset(1'h1);
		repeat (PU + 20) @(negedge clk);
		chk("diag_abiv", 4'hE, {a, b, idx, vld});
		@(posedge clk);
		rel_n <= 1'h0;
		wait_valid(125);
		@(posedge clk);
		rel_n <= 1'h1;
		repeat (20) @(negedge clk);
		chk("stay_valid", 1, vld);
	endtask : t_diag
	initial begin
		t_auto();
		t_move();
		t_diag();
		summarize();
	end
endmodule : testbench
bind aqe_encoder aqe_props #(.POWER_UP_INTERVAL_CYC(POWER_UP_INTERVAL_CYC)) i_props (.ref_clk_in, .rst_in, .angle_in,
	.output_release_n_in, .phase_a_out, .phase_b_out, .index_out, .outputs_valid_out);
